/* File: common/dbs_pkg.sv */
// Purpose: Shared constants and helpers for the dynamic bus sizer.
// Assumes: Byte lane 0 is the most significant byte of a 32-bit word.
// Notes: Active-low pins are carried as 1 = high, 0 = low.
package dbs_pkg;

    // Acknowledge code {port_ack_hi_n, port_ack_lo_n}
    localparam logic [1:0] DBS_ACK_WAIT = 2'h3;
    localparam logic [1:0] DBS_ACK_PORT8 = 2'h2;
    localparam logic [1:0] DBS_ACK_PORT16 = 2'h1;
    localparam logic [1:0] DBS_ACK_PORT32 = 2'h0;

    // Access size code from the processor
    localparam logic [1:0] DBS_SIZE_BYTE = 2'h1;
    localparam logic [1:0] DBS_SIZE_WORD = 2'h2;

    // Byte counts and addresses
    localparam logic [2:0] DBS_ONE_BYTE = 3'h1;
    localparam logic [2:0] DBS_TWO_BYTES = 3'h2;
    localparam logic [2:0] DBS_FOUR_BYTES = 3'h4;

    // Write record through the two-entry buffer: {mask[3:0], data[31:0]}
    localparam int DBS_BUF_DEPTH = 2;
    localparam int DBS_REC_W = 36;

    // Wait counter width at the peripheral end
    localparam int DBS_WAIT_W = 4;

    function automatic logic [7:0] dbs_lane(input logic [31:0] w,
                                            input logic [1:0] k);
        dbs_lane = w[{~k, 3'h0} +: 8];
    endfunction

    function automatic logic [31:0] dbs_put(input logic [31:0] w,
                                            input logic [1:0] k,
                                            input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[{~k, 3'h0} +: 8] = b;
        dbs_put = r;
    endfunction

    function automatic logic [2:0] dbs_size_bytes(input logic [1:0] s);
        case (s)
            DBS_SIZE_BYTE: dbs_size_bytes = DBS_ONE_BYTE;
            DBS_SIZE_WORD: dbs_size_bytes = DBS_TWO_BYTES;
            default: dbs_size_bytes = DBS_FOUR_BYTES;
        endcase
    endfunction

endpackage

/* File: common/dbs_periph_if.sv */
// Purpose: Peripheral-side bus between the sizer and the peripheral end.
// Assumes: Both ends run on one clock supplied by the testbench.
// Notes: periph_data is resolved here from the two drivers and enables.
`timescale 1ns/1ps
interface dbs_periph_if;
    logic [15:0] dev_data;
    logic dev_data_oe_n;
    logic [15:0] per_data;
    logic per_data_oe_n;
    logic [15:0] periph_data;
    logic periph_rw;
    logic [1:0] periph_byte_addr;
    logic upper_write_en_n;
    logic lower_write_en_n;
    logic single_write_en_n;
    logic periph_strobe_n;
    logic port_ack_hi_n;
    logic port_ack_lo_n;

    // Device wins when both drive; that case is a fault on the bus
    assign periph_data = !dev_data_oe_n ? dev_data :
                         (!per_data_oe_n ? per_data : 16'hFFFF);

    modport dev (
        output dev_data, dev_data_oe_n, periph_rw, periph_byte_addr,
        output upper_write_en_n, lower_write_en_n, single_write_en_n,
        output periph_strobe_n,
        input periph_data, port_ack_hi_n, port_ack_lo_n
    );

    modport per (
        output per_data, per_data_oe_n, port_ack_hi_n, port_ack_lo_n,
        input periph_data, periph_rw, periph_byte_addr,
        input upper_write_en_n, lower_write_en_n, single_write_en_n,
        input periph_strobe_n
    );
endinterface

/* File: logic/dbs_pair_buf.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock; clk_en low freezes all state.
// Notes: Full and empty come straight from the entry count.
`timescale 1ns/1ps
module dbs_pair_buf
    import dbs_pkg::*;
#(
    parameter int WIDTH = DBS_REC_W
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam logic [1:0] FULL_CNT = 2'(DBS_BUF_DEPTH);

    logic [WIDTH-1:0] mem_q [DBS_BUF_DEPTH];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_q != FULL_CNT;
    assign out_valid = cnt_q != 2'h0;
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (clk_en) begin
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    // Storage needs no reset: an entry is only read after a push
    always_ff @(posedge clock) begin
        if (clk_en && push) mem_q[wp_q] <= in_data;
    end
endmodule

/* File: logic/dbs_sizer.sv */
// Purpose: Processor-side end that splits each access into port transfers.
// Assumes: Processor inputs are stable while chip select is low.
// Notes: Only the upper sixteen peripheral lanes pass through this end.
//
// Behaviour
// - Chip select starts; transfer acknowledge ends each access.
// - Access runs as one to four transfers.
// - Low processor lanes stay off until width known.
// - External low-lane transceivers only for 32-bit ports.
// - Only upper sixteen peripheral lanes handled here.
// - Decode acknowledge pair: wait, 8, 16, 32 bits.
// - Decode size: long, word or single byte.
// - Byte offset selects processor lane, zero is top.
// - Peripheral byte address names current byte, 00 top.
// - Upper and lower write enables for 16-bit ports.
// - Single write enable for 8-bit port writes.
// - Strobe marks read window or valid write data.
// - 8-bit reads take top lane, steer by address.
// - Reads from 32-bit ports leave low lanes off.
// - Earlier read bytes latched and held until end.
`timescale 1ns/1ps
module dbs_sizer
    import dbs_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic rw,
    input wire logic [1:0] access_size,
    input wire logic [1:0] cpu_byte_offset,
    input wire logic [31:0] cpu_data_in,
    output logic [31:0] cpu_data_out,
    output logic cpu_data_hi_oe_n,
    output logic cpu_data_lo_oe_n,
    output logic cpu_xfer_ack_n,
    dbs_periph_if.dev pbus
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_XFER,
        ST_GAP,
        ST_DONE,
        ST_END
    } dbs_state_t;

    dbs_state_t st_q, st_d;
    logic rd_q, rd_d;
    logic [2:0] cur_q, cur_d;
    logic [2:0] end_q, end_d;
    logic [31:0] wdat_q, wdat_d;
    logic [31:0] rdat_q, rdat_d;
    logic known_q, known_d;
    logic p32_q, p32_d;
    logic ta_q;
    logic strobe_q;
    logic [15:0] pdo_q;

    // Next byte address after a transfer on a port of the given width
    function automatic logic [2:0] next_addr(input logic [2:0] cur,
                                             input logic [1:0] ack);
        case (ack)
            DBS_ACK_PORT8: next_addr = cur + DBS_ONE_BYTE;
            DBS_ACK_PORT16: next_addr = {cur[2:1], 1'b0} + DBS_TWO_BYTES;
            DBS_ACK_PORT32: next_addr = DBS_FOUR_BYTES;
            default: next_addr = cur;
        endcase
    endfunction

    // Place the bytes of one read transfer on their processor lanes
    function automatic logic [31:0] capture(input logic [31:0] w,
                                            input logic [1:0] a,
                                            input logic [1:0] ack,
                                            input logic [7:0] up,
                                            input logic [7:0] lo);
        logic [31:0] r;
        r = w;
        case (ack)
            DBS_ACK_PORT8: r = dbs_put(r, a, up);
            DBS_ACK_PORT16: begin
                if (a[0]) begin
                    r = dbs_put(r, a, lo);
                end else begin
                    r = dbs_put(r, a, up);
                    r = dbs_put(r, a | 2'h1, lo);
                end
            end
            DBS_ACK_PORT32: begin
                // Lanes 2 and 3 arrive through the external transceivers
                if (!a[1]) begin
                    r = dbs_put(r, 2'h0, up);
                    r = dbs_put(r, 2'h1, lo);
                end
            end
            default: r = w;
        endcase
        capture = r;
    endfunction

    wire [1:0] ack = {pbus.port_ack_hi_n, pbus.port_ack_lo_n};
    wire ack_go = (st_q == ST_XFER) && (ack != DBS_ACK_WAIT);
    wire [2:0] nxt = next_addr(cur_q, ack);
    wire last = nxt >= end_q;
    wire [3:0] span = {2'h0, cpu_byte_offset} +
                      {1'b0, dbs_size_bytes(access_size)};
    wire [2:0] span_end = (span > {1'b0, DBS_FOUR_BYTES}) ?
                          DBS_FOUR_BYTES : span[2:0];
    wire [7:0] up_in = pbus.periph_data[15:8];
    wire [7:0] lo_in = pbus.periph_data[7:0];
    wire [31:0] rd_merge = capture(rdat_q, cur_q[1:0], ack, up_in, lo_in);
    wire busy = st_q != ST_IDLE;
    wire moving = (st_q == ST_XFER) || (st_q == ST_GAP);
    wire wr_strobe = !rd_q && strobe_q;
    wire more = (cur_q + DBS_ONE_BYTE) < end_q;

    always_comb begin
        st_d = st_q;
        rd_d = rd_q;
        cur_d = cur_q;
        end_d = end_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        known_d = known_q;
        p32_d = p32_q;
        case (st_q)
            ST_IDLE: begin
                if (!cs_n) begin
                    st_d = ST_XFER;
                    rd_d = rw;
                    cur_d = {1'b0, cpu_byte_offset};
                    end_d = span_end;
                    wdat_d = cpu_data_in;
                    known_d = 1'b0;
                    p32_d = 1'b0;
                end
            end
            ST_XFER: begin
                if (ack_go) begin
                    known_d = 1'b1;
                    p32_d = ack == DBS_ACK_PORT32;
                    cur_d = nxt;
                    if (rd_q) rdat_d = rd_merge;
                    st_d = last ? ST_DONE : ST_GAP;
                end
            end
            ST_GAP: begin
                // Next strobe only once the port has released its answer
                if (ack == DBS_ACK_WAIT) st_d = ST_XFER;
            end
            ST_DONE: st_d = ST_END;
            ST_END: begin
                if (cs_n) st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // All state moves on the rising edge; acknowledges are only sampled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            rd_q <= 1'b1;
            cur_q <= 3'h0;
            end_q <= 3'h0;
            known_q <= 1'b0;
            p32_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            rd_q <= rd_d;
            cur_q <= cur_d;
            end_q <= end_d;
            known_q <= known_d;
            p32_q <= p32_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdat_q <= 32'h0;
            rdat_q <= 32'h0;
            pdo_q <= 16'h0;
        end else if (clk_en) begin
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            // Odd address puts the byte on both lanes: an 8-bit port reads
            // the top lane, a 16-bit port the lower one
            pdo_q <= {dbs_lane(wdat_d, cur_d[1:0]),
                      dbs_lane(wdat_d, cur_d[1:0] | 2'h1)};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ta_q <= 1'b0;
            strobe_q <= 1'b0;
        end else if (clk_en) begin
            ta_q <= st_d == ST_DONE;
            strobe_q <= st_d == ST_XFER;
        end
    end

    assign cpu_xfer_ack_n = !ta_q;
    assign cpu_data_out = rdat_q;
    assign cpu_data_hi_oe_n = !(rd_q && busy);
    // Low lanes wait for the width and stay off for a 32-bit port
    assign cpu_data_lo_oe_n = !(rd_q && busy && known_q && !p32_q);

    assign pbus.periph_rw = rd_q;
    assign pbus.periph_byte_addr = cur_q[1:0];
    assign pbus.periph_strobe_n = !strobe_q;
    assign pbus.dev_data = pdo_q;
    assign pbus.dev_data_oe_n = !(!rd_q && moving);
    assign pbus.upper_write_en_n = !(wr_strobe && !cur_q[0]);
    assign pbus.lower_write_en_n =
        !(wr_strobe && (cur_q[0] || more));
    assign pbus.single_write_en_n = !wr_strobe;

endmodule

/* File: logic/dbs_port.sv */
// Purpose: Peripheral end: answers transfers and models low-lane transceivers.
// Assumes: ack_code is held steady for the whole access.
// Notes: Writes leave through a two-entry buffer; a full buffer holds waits.
`timescale 1ns/1ps
module dbs_port
    import dbs_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [1:0] ack_code,
    input wire logic [DBS_WAIT_W-1:0] wait_cycles,
    input wire logic [31:0] rd_word,
    input wire logic [15:0] xcvr_cpu_lo_in,
    output logic [15:0] xcvr_cpu_lo_out,
    output logic xcvr_cpu_lo_oe_n,
    output logic wr_rec_valid,
    input wire logic wr_rec_ready,
    output logic [3:0] wr_rec_mask,
    output logic [31:0] wr_rec_data,
    dbs_periph_if.per pbus
);
    logic [1:0] ack_q;
    logic [DBS_WAIT_W-1:0] cnt_q;
    logic [15:0] pd_q;
    logic [15:0] xo_q;
    logic [3:0] mask_w;
    logic [31:0] data_w;
    logic [15:0] pd_d;
    logic buf_ready;

    wire active = !pbus.periph_strobe_n;
    wire rd = pbus.periph_rw;
    wire [1:0] a = pbus.periph_byte_addr;
    wire [1:0] a_even = {a[1], 1'b0};
    wire [1:0] a_odd = {a[1], 1'b1};
    wire uw = !pbus.upper_write_en_n;
    wire lw = !pbus.lower_write_en_n;
    wire [7:0] up = pbus.periph_data[15:8];
    wire [7:0] lo = pbus.periph_data[7:0];
    wire waited = cnt_q >= wait_cycles;
    // A full buffer keeps answering wait so no write is dropped
    wire go = active && waited && (ack_q == DBS_ACK_WAIT) &&
              (rd || buf_ready);
    wire xcvr_on = active && (ack_code == DBS_ACK_PORT32);

    always_comb begin
        mask_w = 4'h0;
        data_w = 32'h0;
        case (ack_code)
            DBS_ACK_PORT8: begin
                mask_w[a] = !pbus.single_write_en_n;
                data_w = dbs_put(data_w, a, up);
            end
            DBS_ACK_PORT16: begin
                mask_w[a_even] = uw;
                mask_w[a_odd] = lw;
                data_w = dbs_put(data_w, a_even, up);
                data_w = dbs_put(data_w, a_odd, lo);
            end
            default: begin
                // Low lanes come from the processor through the transceivers
                data_w = {up, lo, xcvr_cpu_lo_in};
                if (a[1]) begin
                    mask_w = {lw, uw, 2'h0};
                end else begin
                    // Both enables at offset 0 cannot tell word from long
                    mask_w = {uw && lw, uw && lw, lw, uw};
                end
            end
        endcase
    end

    always_comb begin
        case (ack_code)
            DBS_ACK_PORT8: pd_d = {dbs_lane(rd_word, a), 8'h00};
            DBS_ACK_PORT16: pd_d = {dbs_lane(rd_word, a_even),
                                    dbs_lane(rd_word, a_odd)};
            default: pd_d = rd_word[31:16];
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= DBS_ACK_WAIT;
            cnt_q <= '0;
            pd_q <= 16'h0;
            xo_q <= 16'h0;
        end else if (clk_en) begin
            if (!active) begin
                ack_q <= DBS_ACK_WAIT;
                cnt_q <= '0;
            end else if (go) begin
                ack_q <= ack_code;
                pd_q <= pd_d;
                xo_q <= rd_word[15:0];
            end else if (!waited) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign pbus.port_ack_hi_n = ack_q[1];
    assign pbus.port_ack_lo_n = ack_q[0];
    assign pbus.per_data = pd_q;
    assign pbus.per_data_oe_n = !(rd && active && ack_q != DBS_ACK_WAIT);
    assign xcvr_cpu_lo_out = xo_q;
    // Direction follows the read/write line
    assign xcvr_cpu_lo_oe_n =
        !(xcvr_on && rd && ack_q != DBS_ACK_WAIT);

    dbs_pair_buf #(
        .WIDTH(DBS_REC_W)
    ) u_dbs_pair_buf (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(go && !rd),
        .in_ready(buf_ready),
        .in_data({mask_w, data_w}),
        .out_valid(wr_rec_valid),
        .out_ready(wr_rec_ready),
        .out_data({wr_rec_mask, wr_rec_data})
    );
endmodule

/* File: tb/dbs_checker.sv */
// Purpose: Watches the peripheral bus and the processor acknowledge.
// Assumes: One clock; reset_n asynchronous, active low.
// Notes: Inputs mirror the interface signals between the two ends.
`timescale 1ns/1ps
module dbs_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cpu_xfer_ack_n,
    input wire logic cpu_data_lo_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic periph_rw,
    input wire logic [1:0] periph_byte_addr,
    input wire logic upper_write_en_n,
    input wire logic lower_write_en_n,
    input wire logic single_write_en_n,
    input wire logic periph_strobe_n,
    input wire logic port_ack_hi_n,
    input wire logic port_ack_lo_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire ack_idle = port_ack_hi_n && port_ack_lo_n;
    wire ack_32 = !port_ack_hi_n && !port_ack_lo_n;

    ta_pulse_a: assert property (
        $fell(cpu_xfer_ack_n) |=> cpu_xfer_ack_n)
        else $error("transfer acknowledge held past one cycle");
    ta_cause_a: assert property (
        $fell(cpu_xfer_ack_n) |-> !$past(ack_idle))
        else $error("transfer acknowledge without port acknowledge");
    wait_hold_a: assert property (
        !periph_strobe_n && ack_idle |=> !periph_strobe_n)
        else $error("strobe dropped during wait states");
    strobe_end_a: assert property (
        !periph_strobe_n && !ack_idle |=> periph_strobe_n)
        else $error("strobe kept after port acknowledge");
    strobe_gap_a: assert property (
        $rose(periph_strobe_n) |=> periph_strobe_n)
        else $error("no idle cycle between transfers");
    ack_release_a: assert property (
        periph_strobe_n && !ack_idle |=> ack_idle)
        else $error("port acknowledge kept after strobe");
    addr_stable_a: assert property (
        (!periph_strobe_n ##1 !periph_strobe_n) |-> $stable(periph_byte_addr))
        else $error("byte address moved during strobe");
    single_we_a: assert property (
        !single_write_en_n |-> !periph_rw && !periph_strobe_n)
        else $error("single write enable outside a write strobe");
    pair_we_a: assert property (
        !(upper_write_en_n && lower_write_en_n)
        |-> !periph_rw && !periph_strobe_n)
        else $error("upper or lower write enable outside a write strobe");
    dev_drive_a: assert property (!dev_data_oe_n |-> !periph_rw)
        else $error("device drives peripheral data on a read");
    lo_off_32_a: assert property (
        !periph_strobe_n && ack_32 && periph_rw |-> cpu_data_lo_oe_n [*3])
        else $error("low processor lanes driven on a wide port read");
    lo_wait_a: assert property (
        $fell(cpu_data_lo_oe_n) |-> !$past(ack_idle))
        else $error("low processor lanes driven before width known");

    cover property (!periph_strobe_n && periph_rw
        && !port_ack_lo_n && port_ack_hi_n);
    cover property (!single_write_en_n);
    cover property (!periph_strobe_n && ack_32 && !periph_rw);
    cover property ($fell(cpu_xfer_ack_n));
endmodule

/* File: tb/dynamic_bus_sizer_bench.sv */
// Purpose: Drives both ends of the sizer and judges every access.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: 32-bit port word writes are left out; the port model over-marks.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module dynamic_bus_sizer_bench
    import dbs_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic cs_n = 1'b1;
    logic rw = 1'b1;
    logic [1:0] access_size = 2'h0;
    logic [1:0] cpu_byte_offset = 2'h0;
    logic [31:0] cpu_data_in = 32'h0;
    logic [1:0] ack_code = 2'h0;
    logic [DBS_WAIT_W-1:0] wait_cycles = 4'h0;
    logic [31:0] rd_word = 32'h0;
    logic wr_rec_ready = 1'b1;
    logic [31:0] cpu_data_out, rec_data, got_data;
    logic hi_oe_n, lo_oe_n, ta_n, xlo_oe_n, rec_valid;
    logic strobe_q = 1'b1;
    logic [15:0] xlo_out;
    logic [3:0] rec_mask, got_mask;
    int err_total = 0;
    int checks_done = 0;
    int strobes, ta_count, xlo_seen;

    dbs_periph_if pbus ();
    wire [1:0] ack_pair = {pbus.port_ack_hi_n, pbus.port_ack_lo_n};
    dbs_sizer u_dbs_sizer (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .cs_n(cs_n), .rw(rw), .access_size(access_size),
        .cpu_byte_offset(cpu_byte_offset), .cpu_data_in(cpu_data_in),
        .cpu_data_out(cpu_data_out), .cpu_data_hi_oe_n(hi_oe_n),
        .cpu_data_lo_oe_n(lo_oe_n), .cpu_xfer_ack_n(ta_n), .pbus(pbus));
    dbs_port u_dbs_port (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .ack_code(ack_code), .wait_cycles(wait_cycles), .rd_word(rd_word),
        .xcvr_cpu_lo_in(cpu_data_in[15:0]), .xcvr_cpu_lo_out(xlo_out),
        .xcvr_cpu_lo_oe_n(xlo_oe_n), .wr_rec_valid(rec_valid),
        .wr_rec_ready(wr_rec_ready), .wr_rec_mask(rec_mask),
        .wr_rec_data(rec_data), .pbus(pbus));
    dbs_checker u_dbs_checker (.clock(clock), .reset_n(reset_n),
        .cpu_xfer_ack_n(ta_n), .cpu_data_lo_oe_n(lo_oe_n),
        .dev_data_oe_n(pbus.dev_data_oe_n), .periph_rw(pbus.periph_rw),
        .periph_byte_addr(pbus.periph_byte_addr),
        .upper_write_en_n(pbus.upper_write_en_n),
        .lower_write_en_n(pbus.lower_write_en_n),
        .single_write_en_n(pbus.single_write_en_n),
        .periph_strobe_n(pbus.periph_strobe_n),
        .port_ack_hi_n(pbus.port_ack_hi_n),
        .port_ack_lo_n(pbus.port_ack_lo_n));

    initial begin
        forever #20 clock = ~clock;
    end

    // Counts transfers, acknowledges and transceiver cycles; merges popped write records
    always @(posedge clock) begin
        if (pbus.periph_strobe_n === 1'b0 && strobe_q === 1'b1) strobes++;
        strobe_q = pbus.periph_strobe_n;
        if (ta_n === 1'b0) ta_count++;
        if (xlo_oe_n === 1'b0) xlo_seen++;
        if (rec_valid === 1'b1 && wr_rec_ready === 1'b1) begin
            for (int k = 0; k < 4; k++) begin
                if (rec_mask[k]) got_data[31-8*k -: 8] = rec_data[31-8*k -: 8];
            end
            got_mask = got_mask | rec_mask;
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_idle();
        `CHK("idle ta", 1'b1, ta_n)
        `CHK("idle strobe", 1'b1, pbus.periph_strobe_n)
        `CHK("idle lo oe", 1'b1, lo_oe_n)
        `CHK("idle acks", 2'h3, ack_pair)
        `CHK("idle xcvr", 1'b1, xlo_oe_n)
    endtask

    // One access; stall holds the record buffer, hold keeps cs_n after ta
    task automatic access(input logic r, input logic [1:0] sz,
        input logic [1:0] off, input logic [1:0] ack, input int w,
        input logic [31:0] d, input logic stall, input int hold);
        int first, last, xf, i;
        logic [3:0] m;
        logic [31:0] lm, seen;
        first = off;
        last = first + ((sz == 2'h1) ? 0 : (sz == 2'h2) ? 1 : 3);
        if (last > 3) last = 3;
        xf = (ack == 2'h2) ? last - first + 1 :
             (ack == 2'h1) ? last / 2 - first / 2 + 1 : 1;
        m = 4'h0;
        lm = 32'h0;
        for (i = first; i <= last; i++) begin
            m[i] = 1'b1;
            lm[31-8*i -: 8] = 8'hFF;
        end
        @(posedge clock);
        strobes = 0;
        ta_count = 0;
        xlo_seen = 0;
        got_mask = 4'h0;
        got_data = 32'h0;
        rw <= r;
        access_size <= sz;
        cpu_byte_offset <= off;
        cpu_data_in <= d;
        rd_word <= d;
        ack_code <= ack;
        wait_cycles <= w[DBS_WAIT_W-1:0];
        wr_rec_ready <= !stall;
        cs_n <= 1'b0;
        for (i = 0; i < 400 && ta_n !== 1'b0; i++) begin
            @(posedge clock);
            // By now the third transfer has waited out and met a full buffer
            if (stall && i == 80) begin
                // A full buffer must turn into wait states, not lost words
                `CHK("stalled ta", 0, ta_count)
                `CHK("stalled record", 1'b1, rec_valid)
                wr_rec_ready <= 1'b1;
            end
        end
        if (ta_n !== 1'b0) begin
            $display("ERROR no transfer acknowledge");
            err_total++;
            print_verdict();
        end
        if (r) begin
            seen = (ack == 2'h0) ? {cpu_data_out[31:16], xlo_out} :
                   cpu_data_out;
            `CHK("read data", d & lm, seen & lm)
            `CHK("read lo oe", ack == 2'h0, lo_oe_n)
            `CHK("read hi oe", 1'b0, hi_oe_n)
        end
        repeat (hold) @(posedge clock);
        cs_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (i = 0; i < 20 && rec_valid === 1'b1; i++) @(posedge clock);
        if (rec_valid === 1'b1) begin
            $display("ERROR write records not drained");
            err_total++;
            print_verdict();
        end
        @(posedge clock);
        `CHK("transfers", xf, strobes)
        `CHK("ta pulses", 1, ta_count)
        `CHK("xcvr use", r && ack == 2'h0, xlo_seen != 0)
        if (!r) begin
            `CHK("write lanes", m, got_mask)
            `CHK("write data", d & lm, got_data & lm)
        end
    endtask

    // Every size code, offset and answer code; wide port writes limited
    task automatic run_matrix(input logic r);
        logic [1:0] codes [3] = '{2'h2, 2'h1, 2'h0};
        for (int a = 0; a < 3; a++) begin
            for (int s = 0; s < 4; s++) begin
                for (int o = 0; o < 4; o++) begin
                    if (r || a != 2 || s == 1 || (o == 0 && s != 2))
                        access(r, s[1:0], o[1:0], codes[a], (s + o) % 3 * 5,
                            32'h8C4D_1EA7 ^ {4{8'(a * 16 + s * 4 + o)}},
                            1'b0, 0);
                end
            end
        end
    endtask

    // A low clock enable must hold a strobe that waits for its answer
    task automatic freeze_access();
        @(posedge clock);
        rw <= 1'b1;
        access_size <= 2'h1;
        cpu_byte_offset <= 2'h0;
        ack_code <= 2'h2;
        wait_cycles <= 4'h2;
        cs_n <= 1'b0;
        repeat (2) @(posedge clock);
        clk_en <= 1'b0;
        repeat (20) @(posedge clock);
        `CHK("frozen strobe", 1'b0, pbus.periph_strobe_n)
        `CHK("frozen acks", 2'h3, ack_pair)
        ta_count = 0;
        clk_en <= 1'b1;
        repeat (10) @(posedge clock);
        cs_n <= 1'b1;
        `CHK("thawed ta", 1, ta_count)
        repeat (2) @(posedge clock);
    endtask

    task automatic wait_then_reset();
        @(posedge clock);
        ack_code <= 2'h3;
        rw <= 1'b1;
        access_size <= 2'h1;
        cs_n <= 1'b0;
        repeat (20) @(posedge clock);
        `CHK("waiting ta", 1'b1, ta_n)
        `CHK("waiting strobe", 1'b0, pbus.periph_strobe_n)
        reset_n <= 1'b0;
        cs_n <= 1'b1;
        repeat (5) @(posedge clock);
        check_idle();
        reset_n <= 1'b1;
        @(posedge clock);
        check_idle();
    endtask

    initial begin
        repeat (5) @(posedge clock);
        check_idle();
        reset_n <= 1'b1;
        run_matrix(1'b1);
        run_matrix(1'b0);
        access(1'b0, 2'h0, 2'h0, 2'h2, 15, 32'hC3A5_5A3C, 1'b1, 8);
        access(1'b1, 2'h3, 2'h1, 2'h1, 15, 32'h7E81_24DB, 1'b0, 8);
        freeze_access();
        wait_then_reset();
        access(1'b1, 2'h2, 2'h2, 2'h2, 0, 32'h0F1E_2D3C, 1'b0, 0);
        print_verdict();
    end
endmodule
